// File: pmc_pkg.sv
// Constants for the peripheral mover channel context block
package pmc_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses), context stride and word indices
  // ----------------------------------------------------------------
  localparam logic [11:0] GLOBAL_CONTROL_STATUS_OFS = 12'h004;
  localparam logic [11:0] PERIPH_CONTROL_OFS = 12'h060;
  localparam logic [11:0] CTX_POINTER_OFS = 12'h0F0;
  localparam logic [11:0] PROXY_BASE_OFS = 12'h100;
  localparam logic [11:0] CTX_WINDOW_OFS = 12'h400;
  localparam logic [11:0] CTX_STRIDE = 12'h010;
  localparam logic [1:0] WORD_SWITCH_ADDRESS = 2'h0;
  localparam logic [1:0] WORD_PERIPHERAL_ADDRESS = 2'h1;
  localparam logic [1:0] WORD_BUFFER_SIZE_OR_COUNT = 2'h2;
  localparam logic [1:0] WORD_TRANSFER_CONTROL = 2'h3;

  // ----------------------------------------------------------------
  // Writable bit masks and reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] GCS_WMASK = 32'h8000_0003;
  localparam logic [31:0] PCR_WMASK = 32'h0003_F8F8;
  localparam logic [31:0] TCR_WMASK = 32'h9FF3_7F7F;
  localparam logic [31:0] BLOCK_COUNT_MASK = 32'h07FF_FFFF;
  localparam logic [31:0] REG_RESET = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int GCS_START_BIT = 31;
  localparam int PCR_AUTO_BUF_BIT = 17;
  localparam int PCR_DIR_BIT = 16;
  localparam int PCR_PBURST_LSB = 12;
  localparam int PCR_PSTEP_BIT = 11;
  localparam int PCR_SBURST_LSB = 4;
  localparam int PCR_SSTEP_BIT = 3;
  localparam int TCR_RUN_BIT = 31;
  localparam int TCR_IMODE_BIT = 28;
  localparam int TCR_IE_BIT = 27;
  localparam int TCR_LINE_LSB = 24;
  localparam int TCR_PWIDTH_LSB = 22;
  localparam int TCR_SWIDTH_LSB = 20;
  localparam int TCR_BCZ_BIT = 16;
  localparam int TCR_RING_WRITE_OFFSET_LSB = 8;
  localparam int TCR_RING_READ_OFFSET_LSB = 0;
  localparam int RING_HI_LSB = 16;

  // Element width codes
  typedef enum logic [1:0] {
    PMC_W8 = 2'b00,
    PMC_W16 = 2'b01,
    PMC_W32 = 2'b10,
    PMC_WRSV = 2'b11
  } pmc_width_t;

endpackage : pmc_pkg

// File: pmc_step_calc.sv
// Next working address and ring/count position for one element moved
`timescale 1ns/1ps
module pmc_step_calc (
  // Mode and field inputs
  input wire logic auto_buf_i,
  input wire logic imode_i,
  input wire logic ie_i,
  input wire logic sstep_const_i,
  input wire logic pstep_const_i,
  input wire logic [1:0] swidth_i,
  input wire logic [1:0] pwidth_i,
  input wire logic [31:0] bsize_i,
  // Working and initial state
  input wire logic [31:0] cur_sa_i,
  input wire logic [31:0] cur_pa_i,
  input wire logic [26:0] pos_i,
  input wire logic [31:0] init_sa_i,
  input wire logic [31:0] init_pa_i,
  // Results
  output logic [31:0] nxt_sa_o,
  output logic [31:0] nxt_pa_o,
  output logic [26:0] nxt_pos_o,
  output logic end_o,
  output logic irq_o
);

  logic [2:0] sbytes;
  logic [2:0] pbytes;
  logic [26:0] limit;
  logic [27:0] sum;
  logic half;

  // ----------------------------------------------------------------
  // Element byte sizes; reserved code treated as 32 bits
  // ----------------------------------------------------------------
  always_comb begin
    case (pmc_pkg::pmc_width_t'(swidth_i))
      pmc_pkg::PMC_W8: sbytes = 3'h1;
      pmc_pkg::PMC_W16: sbytes = 3'h2;
      default: sbytes = 3'h4;
    endcase
    case (pmc_pkg::pmc_width_t'(pwidth_i))
      pmc_pkg::PMC_W8: pbytes = 3'h1;
      pmc_pkg::PMC_W16: pbytes = 3'h2;
      default: pbytes = 3'h4;
    endcase
  end

  // ----------------------------------------------------------------
  // Limit: switch ring size or block byte count
  // ----------------------------------------------------------------
  always_comb begin
    if (auto_buf_i) begin
      limit = {11'h000, bsize_i[15:0]};
    end else begin
      limit = bsize_i[26:0];
    end
    sum = {1'b0, pos_i} + {25'h0000000, sbytes};
    end_o = (sum >= {1'b0, limit});
    half = auto_buf_i && !end_o
      && ({1'b0, pos_i} < {2'b00, limit[26:1]})
      && (sum >= {2'b00, limit[26:1]});
  end

  // ----------------------------------------------------------------
  // Address stepping and ring reload
  // ----------------------------------------------------------------
  always_comb begin
    nxt_sa_o = sstep_const_i ? cur_sa_i
      : cur_sa_i + {29'h00000000, sbytes};
    nxt_pa_o = pstep_const_i ? cur_pa_i
      : cur_pa_i + {29'h00000000, pbytes};
    nxt_pos_o = sum[26:0];
    if (end_o && auto_buf_i) begin
      // Ring wrap restores both addresses and the count
      nxt_sa_o = init_sa_i;
      nxt_pa_o = init_pa_i;
      nxt_pos_o = 27'h0000000;
    end else if (end_o) begin
      nxt_pos_o = limit;
    end
    // Block mode imode=1 is reserved and behaves as end of block
    irq_o = ie_i
      && (end_o || (auto_buf_i && imode_i && half));
  end

endmodule : pmc_step_calc

// File: pmc_channel_context.sv
// Peripheral mover channel configuration, proxy and context storage
// ----------------------------------------------------------------
// ----------------------------------------------------------------
`timescale 1ns/1ps
module pmc_channel_context #(
  parameter int NUM_CH = 16
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Register port from the proxy front manager
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [11:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  output logic [31:0] reg_rdata_o,
  // Transfer engine service port
  input wire logic [3:0] svc_chan_i,
  input wire logic svc_step_i,
  output logic svc_enable_o,
  output logic svc_dir_o,
  output logic [4:0] svc_pburst_o,
  output logic [4:0] svc_sburst_o,
  output logic [1:0] svc_pwidth_o,
  output logic [1:0] svc_swidth_o,
  output logic [31:0] svc_switch_side_address_o,
  output logic [31:0] svc_paddr_o,
  // Ring offset updates from the engine
  input wire logic ptr_upd_i,
  input wire logic [3:0] ptr_chan_i,
  input wire logic [6:0] ring_write_offset_i,
  input wire logic [6:0] ring_read_offset_i,
  // Interrupt request towards the event group
  output logic irq_o,
  output logic [2:0] irq_line_o,
  output logic [3:0] irq_chan_o
);

  localparam int HALF = NUM_CH / 2;

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  if (NUM_CH < 2 || NUM_CH > 16 || (NUM_CH % 2) != 0) begin : g_chk
    $error("NUM_CH must be even and between 2 and 16");
  end

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [31:0] gcs_r;
  logic [31:0] pcr_r [2];
  logic [31:0] proxy_r [4];
  logic [3:0] ctx_ptr_r;
  logic [31:0] ctx_sa_r [NUM_CH];
  logic [31:0] ctx_pa_r [NUM_CH];
  logic [31:0] ctx_bs_r [NUM_CH];
  logic [31:0] ctx_tc_r [NUM_CH];
  logic [31:0] cur_sa_r [NUM_CH];
  logic [31:0] cur_pa_r [NUM_CH];
  logic [26:0] cur_pos_r [NUM_CH];

  logic [3:0] addr_ch;
  logic [1:0] addr_word;
  logic wr_gcs;
  logic wr_ptr;
  logic commit;
  logic sel_grp;
  logic [31:0] sel_pcr;
  logic [31:0] sel_tc;
  logic sel_ok;
  logic step_ok;
  logic [31:0] nxt_sa;
  logic [31:0] nxt_pa;
  logic [26:0] nxt_pos;
  logic step_end;
  logic step_irq;
  logic [31:0] rd_nxt;

  assign addr_ch = reg_addr_i[7:4];
  assign addr_word = reg_addr_i[3:2];
  assign wr_gcs = reg_wr_i
    && reg_addr_i == pmc_pkg::GLOBAL_CONTROL_STATUS_OFS;
  assign wr_ptr = reg_wr_i && reg_addr_i == pmc_pkg::CTX_POINTER_OFS;
  // Pointer write names the channel and fires the copy
  // Whole word is compared, so 0x10 is refused rather than aliasing 0
  assign commit = wr_ptr && (reg_wdata_i < 32'(NUM_CH));

  // ----------------------------------------------------------------
  // Global control: halted from reset until start is written
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      gcs_r <= pmc_pkg::REG_RESET;
    end else if (wr_gcs) begin
      gcs_r <= reg_wdata_i & pmc_pkg::GCS_WMASK;
    end
  end

  // ----------------------------------------------------------------
  // Peripheral control per event group, one word for each half of the channels
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      pcr_r[0] <= pmc_pkg::REG_RESET;
      pcr_r[1] <= pmc_pkg::REG_RESET;
    end else if (reg_wr_i
        && reg_addr_i[11:3] == pmc_pkg::PERIPH_CONTROL_OFS[11:3]) begin
      pcr_r[reg_addr_i[2]] <= reg_wdata_i & pmc_pkg::PCR_WMASK;
    end
  end

  // ----------------------------------------------------------------
  // Proxy words and channel pointer
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      for (int w = 0; w < 4; w++) begin
        proxy_r[w] <= pmc_pkg::REG_RESET;
      end
      ctx_ptr_r <= 4'h0;
    end else begin
      if (reg_wr_i && reg_addr_i[11:4] == pmc_pkg::PROXY_BASE_OFS[11:4]) begin
        proxy_r[addr_word] <= reg_wdata_i;
      end
      if (commit) begin
        ctx_ptr_r <= reg_wdata_i[3:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Service channel decode; lower half of channels is group 0
  // ----------------------------------------------------------------
  always_comb begin
    sel_ok = ({28'h0000000, svc_chan_i} < NUM_CH);
    sel_grp = ({28'h0000000, svc_chan_i} >= HALF);
    sel_pcr = pcr_r[sel_grp];
    sel_tc = sel_ok ? ctx_tc_r[svc_chan_i] : 32'h0000_0000;
    // Engine may move data only with global start and channel run set
    svc_enable_o = sel_ok && gcs_r[pmc_pkg::GCS_START_BIT]
      && sel_tc[pmc_pkg::TCR_RUN_BIT];
    // A finished block stays finished until software reloads it
    step_ok = svc_step_i && svc_enable_o
      && !(sel_tc[pmc_pkg::TCR_BCZ_BIT]
        && !sel_pcr[pmc_pkg::PCR_AUTO_BUF_BIT]);
  end

  // Engine configuration views of the selected channel
  assign svc_dir_o = sel_pcr[pmc_pkg::PCR_DIR_BIT];
  assign svc_pburst_o = {1'b0, sel_pcr[pmc_pkg::PCR_PBURST_LSB +: 4]}
    + 5'h01;
  assign svc_sburst_o = {1'b0, sel_pcr[pmc_pkg::PCR_SBURST_LSB +: 4]}
    + 5'h01;
  assign svc_pwidth_o = sel_tc[pmc_pkg::TCR_PWIDTH_LSB +: 2];
  assign svc_swidth_o = sel_tc[pmc_pkg::TCR_SWIDTH_LSB +: 2];
  assign svc_switch_side_address_o = sel_ok ? cur_sa_r[svc_chan_i] : 32'h0000_0000;
  assign svc_paddr_o = sel_ok ? cur_pa_r[svc_chan_i] : 32'h0000_0000;

  // ----------------------------------------------------------------
  // Step arithmetic for the serviced channel
  // ----------------------------------------------------------------
  pmc_step_calc u_step (
    .auto_buf_i(sel_pcr[pmc_pkg::PCR_AUTO_BUF_BIT]),
    .imode_i(sel_tc[pmc_pkg::TCR_IMODE_BIT]),
    .ie_i(sel_tc[pmc_pkg::TCR_IE_BIT]),
    .sstep_const_i(sel_pcr[pmc_pkg::PCR_SSTEP_BIT]),
    .pstep_const_i(sel_pcr[pmc_pkg::PCR_PSTEP_BIT]),
    .swidth_i(svc_swidth_o),
    .pwidth_i(svc_pwidth_o),
    .bsize_i(sel_ok ? ctx_bs_r[svc_chan_i] : 32'h0000_0000),
    .cur_sa_i(svc_switch_side_address_o),
    .cur_pa_i(svc_paddr_o),
    .pos_i(sel_ok ? cur_pos_r[svc_chan_i] : 27'h0000000),
    .init_sa_i(sel_ok ? ctx_sa_r[svc_chan_i] : 32'h0000_0000),
    .init_pa_i(sel_ok ? ctx_pa_r[svc_chan_i] : 32'h0000_0000),
    .nxt_sa_o(nxt_sa),
    .nxt_pa_o(nxt_pa),
    .nxt_pos_o(nxt_pos),
    .end_o(step_end),
    .irq_o(step_irq)
  );

  // ----------------------------------------------------------------
  // Per-channel context and working state
  // ----------------------------------------------------------------
  // Commit wins over an engine step on the same channel, so a fresh
  // context is never overwritten by stale arithmetic.
  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    logic load;
    logic step;
    assign load = commit && reg_wdata_i[3:0] == 4'(c);
    assign step = step_ok && svc_chan_i == 4'(c);

    always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
        ctx_sa_r[c] <= pmc_pkg::REG_RESET;
        ctx_pa_r[c] <= pmc_pkg::REG_RESET;
        ctx_bs_r[c] <= pmc_pkg::REG_RESET;
        ctx_tc_r[c] <= pmc_pkg::REG_RESET;
      end else if (load) begin
        ctx_sa_r[c] <= proxy_r[pmc_pkg::WORD_SWITCH_ADDRESS];
        ctx_pa_r[c] <= proxy_r[pmc_pkg::WORD_PERIPHERAL_ADDRESS];
        ctx_bs_r[c] <=
          proxy_r[pmc_pkg::WORD_BUFFER_SIZE_OR_COUNT];
        ctx_tc_r[c] <= proxy_r[pmc_pkg::WORD_TRANSFER_CONTROL]
          & pmc_pkg::TCR_WMASK;
      end else begin
        // Flag belongs to block mode only; a ring just wraps
        if (step && step_end
            && !sel_pcr[pmc_pkg::PCR_AUTO_BUF_BIT]) begin
          ctx_tc_r[c][pmc_pkg::TCR_BCZ_BIT] <= 1'b1;
        end
        if (ptr_upd_i && ptr_chan_i == 4'(c)) begin
          ctx_tc_r[c][pmc_pkg::TCR_RING_WRITE_OFFSET_LSB +: 7] <= ring_write_offset_i;
          ctx_tc_r[c][pmc_pkg::TCR_RING_READ_OFFSET_LSB +: 7] <= ring_read_offset_i;
        end
      end
    end

    always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
        cur_sa_r[c] <= pmc_pkg::REG_RESET;
        cur_pa_r[c] <= pmc_pkg::REG_RESET;
        cur_pos_r[c] <= 27'h0000000;
      end else if (load) begin
        cur_sa_r[c] <= proxy_r[pmc_pkg::WORD_SWITCH_ADDRESS];
        cur_pa_r[c] <= proxy_r[pmc_pkg::WORD_PERIPHERAL_ADDRESS];
        cur_pos_r[c] <= 27'h0000000;
      end else if (step) begin
        cur_sa_r[c] <= nxt_sa;
        cur_pa_r[c] <= nxt_pa;
        cur_pos_r[c] <= nxt_pos;
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt pulse with the selected line
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
      irq_line_o <= 3'h0;
      irq_chan_o <= 4'h0;
    end else begin
      irq_o <= step_ok && step_irq;
      if (step_ok && step_irq) begin
        irq_line_o <= sel_tc[pmc_pkg::TCR_LINE_LSB +: 3];
        irq_chan_o <= svc_chan_i;
      end
    end
  end

  // ----------------------------------------------------------------
  // Register read mux; unmapped addresses read zero
  // ----------------------------------------------------------------
  always_comb begin
    rd_nxt = 32'h0000_0000;
    if (reg_addr_i == pmc_pkg::GLOBAL_CONTROL_STATUS_OFS) begin
      rd_nxt = gcs_r;
    end else if (reg_addr_i[11:3] == pmc_pkg::PERIPH_CONTROL_OFS[11:3]) begin
      rd_nxt = pcr_r[reg_addr_i[2]];
    end else if (reg_addr_i == pmc_pkg::CTX_POINTER_OFS) begin
      rd_nxt = {28'h0000000, ctx_ptr_r};
    end else if (reg_addr_i[11:4] == pmc_pkg::PROXY_BASE_OFS[11:4]) begin
      rd_nxt = proxy_r[addr_word];
    end else if (reg_addr_i[11:8] == pmc_pkg::CTX_WINDOW_OFS[11:8]
        && {28'h0000000, addr_ch} < NUM_CH) begin
      // Slot n sits at n times the 16-byte stride
      case (addr_word)
        pmc_pkg::WORD_SWITCH_ADDRESS: rd_nxt = ctx_sa_r[addr_ch];
        pmc_pkg::WORD_PERIPHERAL_ADDRESS: rd_nxt = ctx_pa_r[addr_ch];
        pmc_pkg::WORD_BUFFER_SIZE_OR_COUNT: rd_nxt = ctx_bs_r[addr_ch];
        default: rd_nxt = ctx_tc_r[addr_ch];
      endcase
    end
  end

  // Read data is registered one cycle after the strobe
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      reg_rdata_o <= 32'h0000_0000;
    end else if (reg_rd_i) begin
      reg_rdata_o <= rd_nxt;
    end
  end

endmodule : pmc_channel_context

// File: pmc_props.sv
// Port-level checks for the channel context block
`timescale 1ns/1ps
module pmc_props #(
  parameter int NUM_CH = 16
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Register port
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [11:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic [31:0] reg_rdata_o,
  // Service port
  input wire logic [3:0] svc_chan_i,
  input wire logic svc_step_i,
  input wire logic svc_enable_o,
  input wire logic svc_dir_o,
  input wire logic [4:0] svc_pburst_o,
  input wire logic [4:0] svc_sburst_o,
  input wire logic [1:0] svc_pwidth_o,
  input wire logic [1:0] svc_swidth_o,
  input wire logic [31:0] svc_switch_side_address_o,
  input wire logic [31:0] svc_paddr_o,
  // Ring offsets
  input wire logic ptr_upd_i,
  input wire logic [3:0] ptr_chan_i,
  input wire logic [6:0] ring_write_offset_i,
  input wire logic [6:0] ring_read_offset_i,
  // Interrupt
  input wire logic irq_o,
  input wire logic [2:0] irq_line_o,
  input wire logic [3:0] irq_chan_o
);
  // ------
  // Properties
  // ------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  rst_quiet_a: assert property (disable iff (1'b0)
    rst_i |=> !svc_enable_o && !irq_o && reg_rdata_o == 32'h0)
    else $error("outputs not cleared by reset");
  irq_cause_a: assert property (irq_o |->
    $past(svc_step_i && svc_enable_o) && irq_chan_o == $past(svc_chan_i)
    && irq_chan_o < NUM_CH) else $error("interrupt without a step");
  irq_hold_a: assert property (!irq_o && !$past(rst_i) |->
    $stable(irq_line_o) && $stable(irq_chan_o))
    else $error("interrupt line moved without interrupt");
  rd_hold_a: assert property (!$past(reg_rd_i) && !$past(rst_i) |->
    $stable(reg_rdata_o)) else $error("read data moved without read");
  unmapped_a: assert property (reg_rd_i && reg_addr_i[11:9] == 3'h1
    |=> reg_rdata_o == 32'h0) else $error("unmapped read not zero");
  tcr_mask_a: assert property (reg_rd_i && reg_addr_i[11:8] == 4'h4
    && reg_addr_i[3:0] == 4'hC |=> (reg_rdata_o & ~pmc_pkg::TCR_WMASK) == 0)
    else $error("reserved control bits read nonzero");
  pcr_mask_a: assert property (reg_rd_i && reg_addr_i[11:3] == 9'h00C
    |=> (reg_rdata_o & ~pmc_pkg::PCR_WMASK) == 32'h0)
    else $error("reserved group bits read nonzero");
  burst_range_a: assert property (svc_pburst_o inside {[1:16]} &&
    svc_sburst_o inside {[1:16]}) else $error("burst length out of range");
  addr_hold_a: assert property (!$past(svc_step_i) &&
    !$past(reg_wr_i) && !$past(rst_i) && $stable(svc_chan_i) |->
    $stable(svc_switch_side_address_o) && $stable(svc_paddr_o))
    else $error("address moved without cause");
  enable_hold_a: assert property (!svc_enable_o && !reg_wr_i
    ##1 $stable(svc_chan_i) |-> !svc_enable_o)
    else $error("channel enabled without a write");

  // Main scenarios reached
  cover property (irq_o);
  cover property (svc_step_i && svc_enable_o);
  cover property (reg_wr_i && reg_addr_i == pmc_pkg::CTX_POINTER_OFS);
endmodule : pmc_props

// File: pmc_engine_model.sv
// Transfer engine model that steps the served channel
`timescale 1ns/1ps
module pmc_engine_model (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Commands from the bench
  input wire logic load_i,
  input wire logic [3:0] count_i,
  input wire logic [3:0] gap_i,
  input wire logic blind_i,
  // Channel state from the design
  input wire logic enable_i,
  // Step pulse and status
  output logic step_o,
  output logic busy_o
);
  logic [3:0] left_r;
  logic [3:0] wait_r;

  // Steps only while enabled; blind mode ignores that on purpose
  always_ff @(posedge sys_clk_i) begin
    step_o <= 1'b0;
    if (rst_i) begin
      left_r <= 4'h0;
      wait_r <= 4'h0;
    end else if (load_i) begin
      left_r <= count_i;
    end else if (wait_r != 4'h0) begin
      wait_r <= wait_r - 4'h1;
    end else if (left_r != 4'h0 && (enable_i || blind_i)) begin
      step_o <= 1'b1;
      left_r <= left_r - 4'h1;
      wait_r <= gap_i;
    end
  end

  assign busy_o = (left_r != 4'h0) || step_o;
endmodule : pmc_engine_model

// File: tb_top.sv
// Self-checking bench for the channel context block
`timescale 1ns/1ps
module tb_top;
  // ------
  // Signals and tables
  // ------
  typedef struct {logic [11:0] a; logic [31:0] d; logic [31:0] e;} pmc_reg_t;
  typedef struct {logic [31:0] peripheral_control; logic [31:0] tc; logic [3:0] steps;
    logic [3:0] gap; logic blind; int irq; logic [31:0] sa;
    logic [31:0] pa;} pmc_row_t;
  logic clk, rst, wr, rd, step, enable, dir, irq, upd, load, blind, busy;
  logic [11:0] addr;
  logic [31:0] wdata, rdata, switch_side_address, paddr;
  logic [3:0] chan, pchan, cnt, gap, ichan;
  logic [4:0] pb, sb;
  logic [1:0] pw, sw;
  logic [6:0] wo, ro;
  logic [2:0] line;
  int failures, cmp_count, irq_cnt, n;
  pmc_reg_t regs [4] = '{'{12'h004, 32'hFFFF_FFFF, 32'h8000_0003},
    '{12'h060, 32'hFFFF_FFFF, 32'h0003_F8F8},
    '{12'h064, 32'h0001_5A38, 32'h0001_5838},
    '{12'h200, 32'hFFFF_FFFF, 32'h0}};
  // Ring rows first; the block row stays last for the flag readback
  pmc_row_t rows [9] = '{
    '{32'h2_0000, 32'h9DA0_0000, 1, 0, 0, 1, 32'h1004, 32'h2004},
    '{32'h2_0000, 32'h9DA0_0000, 2, 3, 0, 2, 32'h1000, 32'h2000},
    '{32'h2_0000, 32'h8DA0_0000, 2, 0, 0, 1, 32'h1000, 32'h2000},
    '{32'h2_0000, 32'h95A0_0000, 2, 0, 0, 0, 32'h1000, 32'h2000},
    '{32'h2_0008, 32'h9DA0_0000, 1, 0, 0, 1, 32'h1000, 32'h2004},
    '{32'h2_0000, 32'h9D90_0000, 1, 0, 0, 0, 32'h1002, 32'h2004},
    '{32'h2_0000, 32'h1DA0_0000, 2, 0, 1, 0, 32'h1000, 32'h2000},
    '{32'h2_0800, 32'h9D80_0000, 1, 0, 0, 0, 32'h1001, 32'h2000},
    '{32'h0, 32'h8DA0_0000, 3, 0, 0, 1, 32'h1008, 32'h2008}};
  logic [31:0] ctx [4] = '{32'h1234_5678, 32'h9ABC_DEF0, 32'h8,
    32'h9FF3_7F7F};

  pmc_channel_context i_pmc_channel_context (.sys_clk_i(clk), .rst_i(rst),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_rdata_o(rdata), .svc_chan_i(chan), .svc_step_i(step),
    .svc_enable_o(enable), .svc_dir_o(dir), .svc_pburst_o(pb),
    .svc_sburst_o(sb), .svc_pwidth_o(pw), .svc_swidth_o(sw),
    .svc_switch_side_address_o(switch_side_address), .svc_paddr_o(paddr), .ptr_upd_i(upd),
    .ptr_chan_i(pchan), .ring_write_offset_i(wo), .ring_read_offset_i(ro),
    .irq_o(irq), .irq_line_o(line), .irq_chan_o(ichan));
  pmc_engine_model i_pmc_engine_model (.sys_clk_i(clk), .rst_i(rst),
    .load_i(load), .count_i(cnt), .gap_i(gap), .blind_i(blind),
    .enable_i(enable), .step_o(step), .busy_o(busy));

  // ------
  // Clock, counters and tasks
  // ------
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Pulses are one cycle wide, so count them at every edge
  always @(posedge clk) if (irq === 1'b1) irq_cnt++;

  task automatic chk(input string nm, input logic [31:0] e, g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Strobe drops for a cycle so no signal is set twice in one step
  task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
    wr = 1'b1;
    addr = a;
    wdata = d;
    @(posedge clk) #1;
    wr = 1'b0;
    @(posedge clk) #1;
  endtask : wr_reg
  task automatic rd_reg(input logic [11:0] a, input logic [31:0] e);
    rd = 1'b1;
    addr = a;
    @(posedge clk) #1;
    rd = 1'b0;
    chk("read data", e, rdata);
    @(posedge clk) #1;
  endtask : rd_reg
  task automatic load_ctx(input logic [3:0] ch, input logic [31:0] tc);
    wr_reg(pmc_pkg::PROXY_BASE_OFS, ch == 4'h5 ? ctx[0] : 32'h1000);
    wr_reg(pmc_pkg::PROXY_BASE_OFS + 12'h4, ch == 4'h5 ? ctx[1] : 32'h2000);
    wr_reg(pmc_pkg::PROXY_BASE_OFS + 12'h8, 32'h8);
    wr_reg(pmc_pkg::PROXY_BASE_OFS + 12'hC, tc);
    wr_reg(pmc_pkg::CTX_POINTER_OFS, {28'h0, ch});
  endtask : load_ctx
  task automatic close_out();
    $display("failures %0d comparisons %0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : close_out

  // ------
  // Main sequence
  // ------
  initial begin
    {rst, wr, rd, upd, load, blind} = 6'h20;
    {addr, wdata, chan, pchan, cnt, gap, wo, ro} = '0;
    {failures, cmp_count, irq_cnt} = '0;
    repeat (10) @(posedge clk);
    #1 rst = 1'b0;
    rd_reg(pmc_pkg::GLOBAL_CONTROL_STATUS_OFS, 32'h0);
    chk("enable", 32'h0, {31'h0, enable});
    foreach (regs[i]) begin
      wr_reg(regs[i].a, regs[i].d);
      rd_reg(regs[i].a, regs[i].e);
    end
    chan = 4'hA;
    @(posedge clk) #1;
    chk("group1 bursts", 32'h0001_0604,
      {15'h0, dir, 3'h0, pb, 3'h0, sb});
    chan = 4'h2;
    // Context slots: a wide channel, a neighbour, and a refused pointer
    load_ctx(4'h5, 32'hFFFF_FFFF);
    for (n = 0; n < 4; n++) rd_reg(12'h450 + 12'(4 * n), ctx[n]);
    rd_reg(12'h440, 32'h0);
    wr_reg(pmc_pkg::CTX_POINTER_OFS, 32'h10);
    rd_reg(12'h400, 32'h0);
    foreach (rows[i]) begin
      wr_reg(pmc_pkg::PERIPH_CONTROL_OFS, rows[i].peripheral_control);
      load_ctx(4'h2, rows[i].tc);
      chk("enable", {31'h0, rows[i].tc[31]}, {31'h0, enable});
      chk("pburst", {27'h0, 5'(rows[i].peripheral_control[15:12]) + 5'h1},
        {27'h0, pb});
      chk("swidth", {30'h0, rows[i].tc[21:20]}, {30'h0, sw});
      chk("pwidth", {30'h0, rows[i].tc[23:22]}, {30'h0, pw});
      irq_cnt = 0;
      {cnt, gap, blind} = {rows[i].steps, rows[i].gap, rows[i].blind};
      load = 1'b1;
      @(posedge clk) #1;
      load = 1'b0;
      for (n = 0; n < 100 && busy === 1'b1; n++) @(posedge clk) #1;
      // A stuck engine ends the run through the report
      if (busy !== 1'b0) begin
        chk("engine idle", 32'h0, {31'h0, busy});
        close_out();
      end
      repeat (2) @(posedge clk) #1;
      chk("irq count", 32'(rows[i].irq), 32'(irq_cnt));
      chk("switch addr", rows[i].sa, switch_side_address);
      chk("periph addr", rows[i].pa, paddr);
      if (rows[i].irq > 0)
        chk("irq line", 32'h52, {25'h0, line, ichan});
      // A ring wrap must leave the block flag clear
      if (rows[i].peripheral_control[17])
        rd_reg(12'h42C, rows[i].tc & pmc_pkg::TCR_WMASK);
    end
    rd_reg(12'h42C, 32'h8DA1_0000);
    {upd, pchan, wo, ro} = {1'b1, 4'h2, 7'h55, 7'h2A};
    @(posedge clk) #1;
    upd = 1'b0;
    rd_reg(12'h42C, 32'h8DA1_552A);
    wr_reg(pmc_pkg::GLOBAL_CONTROL_STATUS_OFS, 32'h0);
    chk("enable", 32'h0, {31'h0, enable});
    rst = 1'b1;
    repeat (10) @(posedge clk);
    #1 rst = 1'b0;
    rd_reg(12'h450, 32'h0);
    close_out();
  end
endmodule : tb_top

bind pmc_channel_context pmc_props #(.NUM_CH(NUM_CH)) i_pmc_props (.*);
